// ---- logic/csw_pkg.sv ----
// Constants and types shared by the CAN register window and DMA bridge
`default_nettype none
package csw_pkg;
   // Special function register addresses (pointer and status share one address)
   localparam logic [7:0] SFR_PTR_ADDR    = 8'hd8;
   localparam logic [7:0] SFR_STAT_ADDR   = 8'hd8;
   localparam logic [7:0] SFR_INTCMD_ADDR = 8'hd9;
   localparam logic [7:0] SFR_DATA_ADDR   = 8'hda;
   // Pointer register fields
   localparam int PTR_DMA_BIT  = 7;
   localparam int PTR_RSVD_BIT = 6;
   localparam int PTR_STEP_BIT = 5;
   // Internal register indices
   localparam logic [4:0] IDX_CMD     = 5'h01;
   localparam logic [4:0] IDX_STATUS  = 5'h02;
   localparam logic [4:0] IDX_INT     = 5'h03;
   localparam logic [4:0] IDX_TX_BASE = 5'h0a;
   localparam logic [4:0] IDX_RX_BASE = 5'h14;
   localparam logic [4:0] IDX_RX_LAST = 5'h1d;
   localparam logic [4:0] IDX_TOP     = 5'h1f;
   localparam int         CTRL_BYTES  = 10;
   // Buffer memory layout: transmit, receive store 0, receive store 1
   localparam int         MEM_DEPTH    = 32;
   localparam logic [4:0] MEM_TX_BASE  = 5'h00;
   localparam logic [4:0] MEM_RX0_BASE = 5'h0a;
   localparam logic [4:0] MEM_MSG_SPAN = 5'h0a;
   // Message layout
   localparam logic [3:0] DLC_BYTE  = 4'h1;
   localparam logic [3:0] HDR_BYTES = 4'h2;
   localparam logic [3:0] DLC_MAX   = 4'h8;
   localparam logic [3:0] TX_START  = 4'h0;
   localparam logic [7:0] RAM_LEN_OFS = 8'h01;
   // Command and interrupt bits
   localparam int         CMD_RELEASE_BIT = 2;
   localparam logic [7:0] INT_LIVE_MASK   = 8'h1f;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
   // Worst case transfer: length fetch, wait, ten bytes plus one, wrap-up
   localparam int DMA_MAX_CYCLES = 14;
   typedef enum logic [4:0] {
      DMA_IDLE  = 5'b00001,
      DMA_LEN   = 5'b00010,
      DMA_LWAIT = 5'b00100,
      DMA_COPY  = 5'b01000,
      DMA_DRAIN = 5'b10000
   } csw_dma_state_t;
endpackage
`default_nettype wire

// ---- logic/csw_buf_mem.sv ----
// Two-port buffer memory with registered read data on both ports
`timescale 1ns/10ps
`default_nettype none
module csw_buf_mem #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] a_addr,
   input  wire logic          a_we,
   input  wire logic [7:0]    a_wdata,
   output logic      [7:0]    a_rdata,
   input  wire logic [AW-1:0] b_addr,
   input  wire logic          b_we,
   input  wire logic [7:0]    b_wdata,
   output logic      [7:0]    b_rdata
);
   logic [7:0] mem [DEPTH];

   // Writes; port A wins a same-address collision
   always_ff @(posedge sys_clk) begin
      if (b_we && !(a_we && a_addr == b_addr)) begin
         mem[b_addr] <= b_wdata;
      end
      if (a_we) begin
         mem[a_addr] <= a_wdata;
      end
   end

   // Registered reads, old data on a same-cycle write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         a_rdata <= csw_pkg::BYTE_RESET;
         b_rdata <= csw_pkg::BYTE_RESET;
      end else begin
         a_rdata <= mem[a_addr];
         b_rdata <= mem[b_addr];
      end
   end
endmodule // csw_buf_mem
`default_nettype wire

// ---- logic/csw_msg_len.sv ----
// Message byte count from a data length code byte
`timescale 1ns/10ps
`default_nettype none
module csw_msg_len (
   input  wire logic [7:0] dlc_byte,
   output logic      [3:0] msg_len
);
   // Codes above eight still mean eight data bytes
   always_comb begin
      if (dlc_byte[3:0] > csw_pkg::DLC_MAX) begin
         msg_len = 4'(csw_pkg::HDR_BYTES + csw_pkg::DLC_MAX);
      end else begin
         msg_len = 4'(csw_pkg::HDR_BYTES + dlc_byte[3:0]);
      end
   end
endmodule // csw_msg_len
`default_nettype wire

// ---- logic/csw_sfr_bridge.sv ----
// CPU special function register window and message DMA for the CAN controller
`timescale 1ns/10ps
`default_nettype none
module csw_sfr_bridge #(
   parameter int MEM_DEPTH = csw_pkg::MEM_DEPTH
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   input  wire logic [7:0]                    sfr_addr,
   input  wire logic                          sfr_sel_status,
   input  wire logic                          sfr_wr,
   input  wire logic                          sfr_rd,
   input  wire logic [7:0]                    sfr_wdata,
   output logic      [7:0]                    sfr_rdata,
   output logic                               sfr_rvalid,
   output logic                               ram_rd,
   output logic                               ram_wr,
   output logic      [7:0]                    ram_addr,
   output logic      [7:0]                    ram_wdata,
   input  wire logic [7:0]                    ram_rdata,
   output logic                               dma_busy,
   input  wire logic [7:0]                    core_status,
   input  wire logic [7:0]                    core_irq,
   output logic                               cmd_wr,
   output logic      [7:0]                    cmd_data,
   output logic                               irq_read,
   output logic      [csw_pkg::CTRL_BYTES*8-1:0] ctrl_seg,
   input  wire logic [3:0]                    core_tx_idx,
   output logic      [7:0]                    core_tx_data,
   input  wire logic                          core_rx_we,
   input  wire logic [3:0]                    core_rx_idx,
   input  wire logic [7:0]                    core_rx_data,
   input  wire logic                          core_rx_commit,
   output logic                               rx_avail,
   output logic                               rx_room
);
   localparam int DMA_BOUND = csw_pkg::DMA_MAX_CYCLES;

   logic [7:0]               ptr_reg;
   logic [7:0]               ram_ptr;
   logic [7:0]               ctrl_q [csw_pkg::CTRL_BYTES];
   logic [4:0]               idx;
   logic                     wr_ptr, wr_stat, wr_ic, wr_dat;
   logic                     rd_ptr, rd_stat, rd_ic, rd_dat, rd_any, acc_dat;
   logic                     cmd_hit, release_rx, dma_go, start_is_tx;
   logic                     win_in_tx, win_in_rx, win_in_mem;
   logic [4:0]               win_mem_addr, rx_vis_base, rx_wr_base;
   logic [7:0]               win_ctrl_value, rd_value;
   csw_pkg::csw_dma_state_t  dma_state;
   logic                     dma_tx, pend;
   logic [3:0]               src_i, end_i, start_i, pend_i, msg_len;
   logic [7:0]               dlc_src;
   logic                     rx_sel;
   logic [1:0]               rx_full, next_full;
   logic                     next_sel;
   logic                     rd1_valid, rd1_mem;
   logic [7:0]               rd1_byte;
   logic [4:0]               a_addr, b_addr;
   logic                     a_we;
   logic [7:0]               a_wdata, a_rdata;

   assign idx = ptr_reg[4:0];
   assign dma_busy = (dma_state != csw_pkg::DMA_IDLE);

   // Port decode; pointer and status share an address, told apart by the select
   assign wr_ptr  = sfr_wr && sfr_addr == csw_pkg::SFR_PTR_ADDR && !sfr_sel_status;
   assign wr_stat = sfr_wr && sfr_addr == csw_pkg::SFR_STAT_ADDR && sfr_sel_status;
   assign wr_ic   = sfr_wr && sfr_addr == csw_pkg::SFR_INTCMD_ADDR;
   assign wr_dat  = sfr_wr && sfr_addr == csw_pkg::SFR_DATA_ADDR;
   assign rd_ptr  = sfr_rd && sfr_addr == csw_pkg::SFR_PTR_ADDR && !sfr_sel_status;
   assign rd_stat = sfr_rd && sfr_addr == csw_pkg::SFR_STAT_ADDR && sfr_sel_status;
   assign rd_ic   = sfr_rd && sfr_addr == csw_pkg::SFR_INTCMD_ADDR;
   assign rd_dat  = sfr_rd && sfr_addr == csw_pkg::SFR_DATA_ADDR;
   assign rd_any  = rd_ptr || rd_stat || rd_ic || rd_dat;
   assign acc_dat = wr_dat || rd_dat;

   // Window target; memory belongs to the DMA while it runs
   assign win_in_tx  = idx >= csw_pkg::IDX_TX_BASE && idx < csw_pkg::IDX_RX_BASE;
   assign win_in_rx  = idx >= csw_pkg::IDX_RX_BASE && idx <= csw_pkg::IDX_RX_LAST;
   assign win_in_mem = win_in_tx || win_in_rx;
   assign rx_vis_base = rx_sel ? 5'(csw_pkg::MEM_RX0_BASE + csw_pkg::MEM_MSG_SPAN)
                               : csw_pkg::MEM_RX0_BASE;
   assign rx_wr_base  = rx_sel ? csw_pkg::MEM_RX0_BASE
                               : 5'(csw_pkg::MEM_RX0_BASE + csw_pkg::MEM_MSG_SPAN);
   assign win_mem_addr = win_in_tx ? 5'(idx - csw_pkg::IDX_TX_BASE + csw_pkg::MEM_TX_BASE)
                                   : 5'(idx - csw_pkg::IDX_RX_BASE + rx_vis_base);

   // Command writes, either direct or through the window
   assign cmd_hit    = (wr_ic || (wr_dat && idx == csw_pkg::IDX_CMD)) && !dma_busy;
   assign release_rx = cmd_hit && sfr_wdata[csw_pkg::CMD_RELEASE_BIT];

   // DMA may start only on a valid buffer index
   assign start_is_tx = sfr_wdata[4:0] == csw_pkg::IDX_TX_BASE;
   assign dma_go = wr_ptr && !dma_busy && sfr_wdata[csw_pkg::PTR_DMA_BIT] &&
                   (start_is_tx || (sfr_wdata[4:0] >= csw_pkg::IDX_RX_BASE &&
                                    sfr_wdata[4:0] <= csw_pkg::IDX_RX_LAST));

   // Pointer register: load, step, and wrap-up after a transfer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ptr_reg <= csw_pkg::BYTE_RESET;
      end else if (dma_state == csw_pkg::DMA_DRAIN) begin
         ptr_reg[csw_pkg::PTR_DMA_BIT]  <= 1'b0;
         ptr_reg[csw_pkg::PTR_STEP_BIT] <= 1'b0;
      end else if (wr_ptr && !dma_busy) begin
         ptr_reg <= {dma_go, 1'b0, sfr_wdata[5:0]};
      end else if (acc_dat && ptr_reg[csw_pkg::PTR_STEP_BIT] && !dma_busy) begin
         ptr_reg[4:0] <= 5'(idx + 5'h01);
         if (idx == csw_pkg::IDX_TOP) begin
            ptr_reg[csw_pkg::PTR_STEP_BIT] <= 1'b0;
         end
      end
   end

   // RAM address for the next transfer; status itself is never written
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ram_ptr <= csw_pkg::BYTE_RESET;
      end else if (wr_stat && !dma_busy) begin
         ram_ptr <= sfr_wdata;
      end
   end

   // Control segment bytes; writes to the live register indices are stored here too
   for (genvar g = 0; g < csw_pkg::CTRL_BYTES; g++) begin : g_ctrl
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            ctrl_q[g] <= csw_pkg::BYTE_RESET;
         end else if (wr_dat && !dma_busy && idx == 5'(g)) begin
            ctrl_q[g] <= sfr_wdata;
         end
      end
      assign ctrl_seg[g*8 +: 8] = ctrl_q[g];
   end

   // Command strobe and interrupt-read strobe towards the core
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmd_wr   <= 1'b0;
         cmd_data <= csw_pkg::BYTE_RESET;
         irq_read <= 1'b0;
      end else begin
         cmd_wr   <= cmd_hit;
         irq_read <= rd_ic || (rd_dat && idx == csw_pkg::IDX_INT);
         if (cmd_hit) begin
            cmd_data <= sfr_wdata;
         end
      end
   end

   // Window value for registers outside the buffer memory
   always_comb begin
      win_ctrl_value = csw_pkg::BYTE_RESET;
      if (idx == csw_pkg::IDX_STATUS) begin
         win_ctrl_value = core_status;
      end else if (idx == csw_pkg::IDX_INT) begin
         win_ctrl_value = core_irq & csw_pkg::INT_LIVE_MASK;
      end else if (idx != csw_pkg::IDX_CMD && idx < 5'(csw_pkg::CTRL_BYTES)) begin
         win_ctrl_value = ctrl_q[idx[3:0]];
      end
   end

   // Read value per port
   always_comb begin
      rd_value = win_ctrl_value;
      if (rd_ptr) begin
         rd_value = {ptr_reg[7], 1'b0, ptr_reg[5:0]};
      end else if (rd_stat) begin
         rd_value = core_status;
      end else if (rd_ic) begin
         rd_value = core_irq & csw_pkg::INT_LIVE_MASK;
      end
   end

   // Two-stage read: memory data only settles one edge after the address
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd1_valid  <= 1'b0;
         rd1_mem    <= 1'b0;
         rd1_byte   <= csw_pkg::BYTE_RESET;
         sfr_rvalid <= 1'b0;
         sfr_rdata  <= csw_pkg::BYTE_RESET;
      end else begin
         rd1_valid  <= rd_any;
         rd1_mem    <= rd_dat && win_in_mem;
         rd1_byte   <= rd_value;
         sfr_rvalid <= rd1_valid;
         if (rd1_valid) begin
            sfr_rdata <= rd1_mem ? a_rdata : rd1_byte;
         end
      end
   end

   // DMA sequencer: fetch length, then copy one byte per clock
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dma_state <= csw_pkg::DMA_IDLE;
         dma_tx    <= 1'b0;
         start_i   <= csw_pkg::TX_START;
         src_i     <= csw_pkg::TX_START;
         end_i     <= csw_pkg::TX_START;
      end else begin
         case (dma_state)
            csw_pkg::DMA_IDLE: begin
               if (dma_go) begin
                  dma_state <= csw_pkg::DMA_LEN;
                  dma_tx    <= start_is_tx;
                  start_i   <= start_is_tx ? csw_pkg::TX_START
                                           : 4'(sfr_wdata[4:0] - csw_pkg::IDX_RX_BASE);
               end
            end
            csw_pkg::DMA_LEN: begin
               dma_state <= csw_pkg::DMA_LWAIT;
            end
            csw_pkg::DMA_LWAIT: begin
               end_i     <= msg_len;
               src_i     <= start_i;
               dma_state <= csw_pkg::DMA_COPY;
            end
            csw_pkg::DMA_COPY: begin
               if (src_i < end_i) begin
                  src_i <= 4'(src_i + 4'h1);
               end else begin
                  dma_state <= csw_pkg::DMA_DRAIN;
               end
            end
            csw_pkg::DMA_DRAIN: begin
               dma_state <= csw_pkg::DMA_IDLE;
            end
            default: begin
               dma_state <= csw_pkg::DMA_IDLE;
            end
         endcase
      end
   end

   // Destination write trails the source read by one clock
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend   <= 1'b0;
         pend_i <= csw_pkg::TX_START;
      end else begin
         pend   <= dma_state == csw_pkg::DMA_COPY && src_i < end_i;
         pend_i <= src_i;
      end
   end

   assign dlc_src = dma_tx ? ram_rdata : a_rdata;

   csw_msg_len u_len (
      .dlc_byte (dlc_src),
      .msg_len  (msg_len)
   );

   // Memory port A: CPU window, or the DMA while busy
   always_comb begin
      a_addr  = win_mem_addr;
      a_we    = wr_dat && win_in_mem && !dma_busy;
      a_wdata = sfr_wdata;
      if (!dma_tx && dma_state == csw_pkg::DMA_LEN) begin
         a_addr = 5'(rx_vis_base + {1'b0, csw_pkg::DLC_BYTE});
      end else if (!dma_tx && dma_state == csw_pkg::DMA_COPY) begin
         a_addr = 5'(rx_vis_base + {1'b0, src_i});
      end else if (dma_tx && pend) begin
         a_we    = 1'b1;
         a_addr  = 5'(csw_pkg::MEM_TX_BASE + {1'b0, pend_i});
         a_wdata = ram_rdata;
      end
   end

   // Main RAM requests; the CPU leaves RAM alone while busy
   always_comb begin
      ram_rd   = 1'b0;
      ram_wr   = 1'b0;
      ram_addr = ram_ptr;
      if (dma_tx && dma_state == csw_pkg::DMA_LEN) begin
         ram_rd   = 1'b1;
         ram_addr = 8'(ram_ptr + csw_pkg::RAM_LEN_OFS);
      end else if (dma_tx && dma_state == csw_pkg::DMA_COPY && src_i < end_i) begin
         ram_rd   = 1'b1;
         ram_addr = 8'(ram_ptr + {4'h0, src_i});
      end else if (!dma_tx && pend) begin
         ram_wr   = 1'b1;
         ram_addr = 8'(ram_ptr + {4'h0, 4'(pend_i - start_i)});
      end
   end
   assign ram_wdata = a_rdata;

   // Receive store bookkeeping; a release and a commit in one cycle act on different stores
   always_comb begin
      next_full = rx_full;
      if (release_rx) begin
         next_full[rx_sel] = 1'b0;
      end
      if (core_rx_commit) begin
         next_full[!rx_sel] = 1'b1;
      end
      next_sel = rx_sel;
      if (!next_full[rx_sel] && next_full[!rx_sel]) begin
         next_sel = !rx_sel;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_full <= 2'b00;
         rx_sel  <= 1'b0;
      end else begin
         rx_full <= next_full;
         rx_sel  <= next_sel;
      end
   end
   assign rx_avail = rx_full[rx_sel];
   assign rx_room  = !rx_full[!rx_sel];

   // Core port B: receive writes into the hidden store, else transmit reads
   assign b_addr = core_rx_we ? 5'(rx_wr_base + {1'b0, core_rx_idx})
                              : 5'(csw_pkg::MEM_TX_BASE + {1'b0, core_tx_idx});

   csw_buf_mem #(
      .DEPTH (MEM_DEPTH),
      .AW    (5)
   ) u_mem (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .a_addr  (a_addr),
      .a_we    (a_we),
      .a_wdata (a_wdata),
      .a_rdata (a_rdata),
      .b_addr  (b_addr),
      .b_we    (core_rx_we),
      .b_wdata (core_rx_data),
      .b_rdata (core_tx_data)
   );

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_step_access;
      acc_dat && ptr_reg[csw_pkg::PTR_STEP_BIT] && !dma_busy;
   endsequence
   sequence s_tx_go;
      dma_go && start_is_tx;
   endsequence

   property p_step_advance;
      s_step_access and (idx != csw_pkg::IDX_TOP) |=> idx == 5'($past(idx) + 5'h01);
   endproperty
   a_step_advance: assert property (p_step_advance) else $error("step did not advance");
   property p_step_wrap;
      s_step_access and (idx == csw_pkg::IDX_TOP) |=> !ptr_reg[csw_pkg::PTR_STEP_BIT];
   endproperty
   a_step_wrap: assert property (p_step_wrap) else $error("step enable kept at wrap");
   property p_dma_bound;
      dma_go |=> ##[1:DMA_BOUND] !dma_busy; // Busy rises one edge after the start
   endproperty
   a_dma_bound: assert property (p_dma_bound) else $error("transfer too long");
   property p_dma_clear;
      $fell(dma_busy) |-> !ptr_reg[csw_pkg::PTR_DMA_BIT] && !ptr_reg[csw_pkg::PTR_STEP_BIT];
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("bits left after transfer");
   property p_ram_ptr;
      wr_stat && !dma_busy |=> ram_ptr == $past(sfr_wdata) && ptr_reg == $past(ptr_reg);
   endproperty
   a_ram_ptr: assert property (p_ram_ptr) else $error("ram address not loaded");
   property p_read_lat;
      rd_any |-> ##2 sfr_rvalid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer missing");
   property p_cmd;
      cmd_hit |=> cmd_wr && cmd_data == $past(sfr_wdata);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not passed on");
   property p_rsvd;
      rd_ptr || rd_ic |-> ##2 !sfr_rdata[csw_pkg::PTR_RSVD_BIT];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
   property p_tx_len;
      s_tx_go |=> ram_rd && ram_addr == 8'(ram_ptr + csw_pkg::RAM_LEN_OFS) ##2 dma_tx;
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("length fetch wrong");
   property p_dlc_limit;
      pend |-> pend_i < end_i && end_i <= 4'(csw_pkg::HDR_BYTES + csw_pkg::DLC_MAX);
   endproperty
   a_dlc_limit: assert property (p_dlc_limit) else $error("copy beyond length");
   property p_rx_alt;
      release_rx && rx_full[!rx_sel] |=> rx_sel != $past(rx_sel);
   endproperty
   a_rx_alt: assert property (p_rx_alt) else $error("stores did not alternate");
endmodule // csw_sfr_bridge
`default_nettype wire

// ---- dv/csw_cpu_ram.sv ----
// Main RAM model answering the DMA engine
`timescale 1ns/10ps
`default_nettype none
module csw_cpu_ram (
   input  wire logic       sys_clk,
   input  wire logic       ram_rd,
   input  wire logic       ram_wr,
   input  wire logic [7:0] ram_addr,
   input  wire logic [7:0] ram_wdata,
   output logic      [7:0] ram_rdata
);
   logic [7:0] mem [256];
   // One-cycle read latency; idle cycles invert the data so stale bytes never match
   always @(posedge sys_clk) begin
      if (ram_wr)
         mem[ram_addr] <= ram_wdata;
      ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
   end
endmodule // csw_cpu_ram
`default_nettype wire

// ---- dv/csw_sfr_bridge_tb_top.sv ----
// Self-checking testbench for the register window and DMA bridge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
   num_checks++; \
   if ((a) !== (b)) begin \
      err_total++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
   end
module csw_sfr_bridge_tb_top;
   localparam logic [7:0] A_PTR = csw_pkg::SFR_PTR_ADDR;
   localparam logic [7:0] A_CMD = csw_pkg::SFR_INTCMD_ADDR;
   localparam logic [7:0] A_DAT = csw_pkg::SFR_DATA_ADDR;
   logic       sys_clk        = 1'b0;
   logic       rst_n          = 1'b0;
   logic       sfr_sel_status = 1'b0;
   logic       sfr_wr         = 1'b0;
   logic       sfr_rd         = 1'b0;
   logic       core_rx_we     = 1'b0;
   logic       core_rx_commit = 1'b0;
   logic [7:0] sfr_addr       = 8'h00;
   logic [7:0] sfr_wdata      = 8'h00;
   logic [7:0] core_status    = 8'ha5;
   logic [7:0] core_irq       = 8'hff;
   logic [3:0] core_rx_idx    = 4'h0;
   logic [7:0] core_rx_data   = 8'h00;
   logic [7:0] sfr_rdata, ram_addr, ram_wdata, ram_rdata, cmd_data, last_cmd;
   logic       sfr_rvalid, ram_rd, ram_wr, dma_busy, cmd_wr, irq_read, rx_avail, rx_room;
   int         err_total  = 0;
   int         num_checks = 0;
   int         irq_reads  = 0;
   logic [7:0] core_tx_data;
   logic [csw_pkg::CTRL_BYTES*8-1:0] ctrl_seg;
   csw_sfr_bridge u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_sel_status(sfr_sel_status), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
      .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata), .dma_busy(dma_busy), .core_status(core_status),
      .core_irq(core_irq), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .irq_read(irq_read),
      .ctrl_seg(ctrl_seg), .core_tx_idx(4'h0), .core_tx_data(core_tx_data),
      .core_rx_we(core_rx_we),
      .core_rx_idx(core_rx_idx), .core_rx_data(core_rx_data),
      .core_rx_commit(core_rx_commit), .rx_avail(rx_avail), .rx_room(rx_room));
   csw_cpu_ram u_ram (.sys_clk(sys_clk), .ram_rd(ram_rd), .ram_wr(ram_wr),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
   always #2.5 sys_clk = ~sys_clk;
   // Command pulses last one cycle, so latch the byte they carry
   always @(posedge sys_clk)
      if (cmd_wr)
         last_cmd <= cmd_data;
   // Interrupt-read pulses also last one cycle, so count them
   always @(posedge sys_clk)
      if (irq_read === 1'b1)
         irq_reads++;
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Write strobe for one edge, then one idle edge before the next request
   task automatic wr(input logic [7:0] a, input logic st, input logic [7:0] d);
      sfr_addr = a;
      sfr_sel_status = st;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge sys_clk);
      #1 sfr_wr = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic st, input logic [7:0] e);
      int n;
      n = 0;
      sfr_addr = a;
      sfr_sel_status = st;
      sfr_rd = 1'b1;
      @(posedge sys_clk);
      #1 sfr_rd = 1'b0;
      while (sfr_rvalid !== 1'b1) begin
         @(posedge sys_clk);
         #1 n++;
         if (n > 4) begin
            err_total++;
            test_done;
         end
      end
      `CHK(sfr_rdata, e)
   endtask
   // RAM address first, then pointer with the start bit; stay off the bus while busy
   task automatic dma(input logic [7:0] p, input logic [7:0] ptr);
      int n;
      n = 0;
      wr(A_PTR, 1'b1, p);
      wr(A_PTR, 1'b0, ptr);
      `CHK(dma_busy, 1'b1)
      while (dma_busy === 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (dma_busy !== 1'b0) begin
         err_total++;
         test_done;
      end
      `CHK(n <= 14, 1'b1)
      rdchk(A_PTR, 1'b0, {3'b000, ptr[4:0]});
   endtask
   task automatic t_ptr;
      rdchk(A_PTR, 1'b0, 8'h00);
      wr(A_PTR, 1'b0, 8'h5f);
      rdchk(A_PTR, 1'b0, 8'h1f);
      wr(A_PTR, 1'b0, 8'h81);
      `CHK(dma_busy, 1'b0)
      rdchk(A_PTR, 1'b0, 8'h01);
      wr(A_PTR, 1'b0, 8'h3e);
      wr(A_DAT, 1'b0, 8'h12);
      wr(A_DAT, 1'b0, 8'h34);
      rdchk(A_PTR, 1'b0, 8'h00);
   endtask
   task automatic t_ports;
      wr(A_PTR, 1'b1, 8'h3c);
      rdchk(A_PTR, 1'b1, 8'ha5);
      core_status = 8'h5a;
      rdchk(A_PTR, 1'b1, 8'h5a);
      rdchk(A_CMD, 1'b0, 8'h1f);
      `CHK(irq_reads, 1)
      wr(A_PTR, 1'b0, 8'h22);
      rdchk(A_DAT, 1'b0, 8'h5a);
      rdchk(A_DAT, 1'b0, 8'h1f);
      `CHK(irq_reads, 2)
      wr(A_DAT, 1'b0, 8'h6c);
      `CHK(ctrl_seg[39:32], 8'h6c)
      wr(A_PTR, 1'b0, 8'h04);
      rdchk(A_DAT, 1'b0, 8'h6c);
      wr(A_CMD, 1'b0, 8'h81);
      `CHK(last_cmd, 8'h81)
   endtask
   // Byte beyond the length code keeps its old value
   task automatic t_tx;
      for (int i = 0; i < 6; i++)
         u_ram.mem[8'h40 + i] = (i == 1) ? 8'h03 : 8'hc0 + 8'(i);
      wr(A_PTR, 1'b0, 8'h0f);
      wr(A_DAT, 1'b0, 8'h99);
      dma(8'h40, 8'h8a);
      `CHK(core_tx_data, 8'hc0)
      wr(A_PTR, 1'b0, 8'h2a);
      for (int i = 0; i < 6; i++)
         rdchk(A_DAT, 1'b0, (i == 5) ? 8'h99 : u_ram.mem[8'h40 + i]);
   endtask
   // Full-length message so every start index has bytes to copy
   task automatic t_rx;
      logic [7:0] b [10];
      for (int j = 0; j < 10; j++) begin
         b[j] = (j == 1) ? 8'h08 : 8'h50 + 8'(j);
         core_rx_we = 1'b1;
         core_rx_idx = 4'(j);
         core_rx_data = b[j];
         @(posedge sys_clk);
         #1;
      end
      core_rx_we = 1'b0;
      core_rx_commit = 1'b1;
      @(posedge sys_clk);
      #1 core_rx_commit = 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK(rx_avail, 1'b1)
      `CHK(rx_room, 1'b1)
      for (int s = 0; s < 10; s++) begin
         u_ram.mem[8'h8a - s] = 8'hee;
         dma(8'h80, 8'h94 + 8'(s));
         `CHK(u_ram.mem[8'h80], b[s])
         `CHK(u_ram.mem[8'h89 - s], b[9])
         `CHK(u_ram.mem[8'h8a - s], 8'hee)
      end
      wr(A_CMD, 1'b0, 8'h04);
      `CHK(rx_avail, 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      t_ptr;
      t_ports;
      t_tx;
      t_rx;
      test_done;
   end
endmodule // csw_sfr_bridge_tb_top
`default_nettype wire
